// file: rtl/ext_alu_pkg.sv
// constants for the extended memory ALU datapath
package ext_alu_pkg;
  localparam int unsigned ADDR_W = 12; // full data memory address, all sections
  localparam int unsigned APB_AW = 8;

  // register byte offsets
  localparam logic [APB_AW-1:0] OFS_CMD    = 8'h00;
  localparam logic [APB_AW-1:0] OFS_ADDR   = 8'h04;
  localparam logic [APB_AW-1:0] OFS_ACC    = 8'h08;
  localparam logic [APB_AW-1:0] OFS_STATUS = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_RESULT = 8'h10;

  // command register fields
  localparam int unsigned CMD_OP_LSB  = 0;
  localparam int unsigned CMD_BIT_LSB = 4;
  localparam int unsigned CMD_GO_BIT  = 8;

  // status register fields
  localparam int unsigned ST_C    = 0;
  localparam int unsigned ST_AC   = 1;
  localparam int unsigned ST_Z    = 2;
  localparam int unsigned ST_OV   = 3;
  localparam int unsigned ST_SC   = 4;
  localparam int unsigned ST_BUSY = 8;

  // operation codes
  localparam logic [2:0] OP_ADD_MEM_TO_ACC_WITH_CARRY = 3'h0;
  localparam logic [2:0] OP_ADD_WITH_CARRY_INTO_MEM   = 3'h1;
  localparam logic [2:0] OP_ADD_MEM_TO_ACC            = 3'h2;
  localparam logic [2:0] OP_ADD_INTO_MEM              = 3'h3;
  localparam logic [2:0] OP_AND_MEM_TO_ACC            = 3'h4;
  localparam logic [2:0] OP_AND_INTO_MEM              = 3'h5;
  localparam logic [2:0] OP_CLEAR_MEM_BYTE            = 3'h6;
  localparam logic [2:0] OP_CLEAR_MEM_BIT             = 3'h7;

  // reset values
  localparam logic [7:0]        ACC_RST   = 8'h00;
  localparam logic [4:0]        FLAGS_RST = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 12'h000;
endpackage : ext_alu_pkg

// file: rtl/extended_mem_alu_ops.sv
// extended memory ALU: add, and, clear on any data memory byte, APB control
`timescale 1ns/1ps
module extended_mem_alu_ops (
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [ext_alu_pkg::APB_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  output logic      [ext_alu_pkg::ADDR_W-1:0] mem_addr,
  output logic                             mem_rd_en,
  output logic                             mem_wr_en,
  output logic      [7:0]                  mem_wdata,
  input  wire logic [7:0]                  mem_rdata
);
  import ext_alu_pkg::*;

  typedef enum logic [1:0] {st_idle, st_fetch, st_exec} phase_e;

  typedef struct packed {
    phase_e              phase;
    logic [2:0]          op;
    logic [2:0]          bit_sel;
    logic [ADDR_W-1:0]   addr;
    logic [7:0]          acc;
    logic [4:0]          flags;
    logic [7:0]          result;
    logic [ADDR_W-1:0]   mem_addr;
    logic                mem_rd_en;
    logic                mem_wr_en;
    logic [7:0]          mem_wdata;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } state_s;

  state_s st_q;
  state_s st_d;

  // returns {sc, ov, c, ac, sum}
  function automatic logic [11:0] add8(input logic [7:0] a,
                                       input logic [7:0] b,
                                       input logic       cin);
    logic [4:0] lo;
    logic [7:0] low7;
    logic [8:0] full;
    logic       ov;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    low7 = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    ov   = low7[7] ^ full[8];
    return {ov ^ full[7], ov, full[8], lo[4], full[7:0]};
  endfunction : add8

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction : is_zero

  logic        apb_hit;
  logic        apb_done;
  logic [11:0] sum_info;
  logic        use_cin;
  logic [7:0]  res;
  logic        to_acc;
  logic        arith;
  logic        logic_op;

  always_comb begin
    st_d     = st_q;
    apb_hit  = psel && penable && !st_q.pready;
    apb_done = psel && penable && st_q.pready;
    use_cin  = (st_q.op == OP_ADD_MEM_TO_ACC_WITH_CARRY) ||
               (st_q.op == OP_ADD_WITH_CARRY_INTO_MEM);
    sum_info = add8(st_q.acc, mem_rdata, use_cin && st_q.flags[ST_C]);
    arith    = st_q.op[2] == 1'b0;
    logic_op = (st_q.op == OP_AND_MEM_TO_ACC) ||
               (st_q.op == OP_AND_INTO_MEM);
    to_acc   = (st_q.op == OP_ADD_MEM_TO_ACC_WITH_CARRY) ||
               (st_q.op == OP_ADD_MEM_TO_ACC) ||
               (st_q.op == OP_AND_MEM_TO_ACC);
    case (st_q.op)
      OP_AND_MEM_TO_ACC, OP_AND_INTO_MEM:
        res = st_q.acc & mem_rdata;
      OP_CLEAR_MEM_BYTE: res = 8'h00;
      OP_CLEAR_MEM_BIT:  res = mem_rdata & ~(8'h01 << st_q.bit_sel);
      default:
        res = sum_info[7:0];
    endcase

    // apb slave: one wait state, answer registered
    st_d.pready  = apb_hit;
    st_d.pslverr = 1'b0;
    if (apb_hit) begin
      st_d.prdata = 32'h0000_0000;
      case (paddr)
        OFS_CMD:    st_d.prdata = {29'h0, st_q.op};
        OFS_ADDR:   st_d.prdata = {20'h0, st_q.addr};
        OFS_ACC:    st_d.prdata = {24'h0, st_q.acc};
        OFS_STATUS: st_d.prdata = {23'h0, st_q.phase != st_idle, 3'h0,
                                   st_q.flags};
        OFS_RESULT: st_d.prdata = {24'h0, st_q.result};
        default:    st_d.pslverr = 1'b1;
      endcase
    end

    st_d.mem_rd_en = 1'b0;
    st_d.mem_wr_en = 1'b0;
    case (st_q.phase)
      st_idle: begin
        // acc, flags and address are only writable while idle
        if (apb_done && pwrite) begin
          case (paddr)
            OFS_ADDR:   st_d.addr  = pwdata[ADDR_W-1:0];
            OFS_ACC:    st_d.acc   = pwdata[7:0];
            OFS_STATUS: st_d.flags = pwdata[4:0];
            OFS_CMD: begin
              st_d.op      = pwdata[CMD_OP_LSB +: 3];
              st_d.bit_sel = pwdata[CMD_BIT_LSB +: 3];
              if (pwdata[CMD_GO_BIT]) begin
                st_d.phase     = st_fetch;
                st_d.mem_addr  = st_q.addr;
                st_d.mem_rd_en = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      st_fetch: st_d.phase = st_exec;
      st_exec: begin
        st_d.phase  = st_idle;
        st_d.result = res;
        if (to_acc) begin
          st_d.acc = res;
        end else begin
          st_d.mem_wr_en = 1'b1;
          st_d.mem_wdata = res;
        end
        if (arith) begin
          st_d.flags[ST_C]  = sum_info[9];
          st_d.flags[ST_AC] = sum_info[8];
          st_d.flags[ST_OV] = sum_info[10];
          st_d.flags[ST_SC] = sum_info[11];
        end
        if (arith || logic_op) begin
          st_d.flags[ST_Z] = is_zero(res);
        end
      end
      default: st_d.phase = st_idle;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q           <= '0;
      st_q.phase     <= st_idle;
      st_q.addr      <= ADDR_RST;
      st_q.acc       <= ACC_RST;
      st_q.flags     <= FLAGS_RST;
      st_q.mem_addr  <= ADDR_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata    = st_q.prdata;
  assign pready    = st_q.pready;
  assign pslverr   = st_q.pslverr;
  assign mem_addr  = st_q.mem_addr;
  assign mem_rd_en = st_q.mem_rd_en;
  assign mem_wr_en = st_q.mem_wr_en;
  assign mem_wdata = st_q.mem_wdata;

  // checks
  a_full_addr_fetch: assert property (@(posedge clk)
    disable iff (sys_rst)
    mem_rd_en |-> mem_addr == $past(st_q.addr))
    else $error("fetch address not the programmed full address");
  a_adc_acc_sum: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_ADD_MEM_TO_ACC_WITH_CARRY |=>
    st_q.acc == 8'($past(st_q.acc) + $past(mem_rdata)
                   + {7'h00, $past(st_q.flags[ST_C])}))
    else $error("add with carry to acc gave wrong sum");
  a_adcm_mem_sum: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_ADD_WITH_CARRY_INTO_MEM |=>
    mem_wr_en && $stable(st_q.acc) && mem_wdata == 8'($past(st_q.acc)
      + $past(mem_rdata) + {7'h00, $past(st_q.flags[ST_C])}))
    else $error("add with carry into memory wrong");
  a_add_carry_out: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_ADD_MEM_TO_ACC |=>
    st_q.flags[ST_C] == ($past({1'b0, st_q.acc}) + $past({1'b0, mem_rdata})
                         > 9'h0ff))
    else $error("plain add carry flag wrong");
  a_addm_acc_kept: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_ADD_INTO_MEM |=>
    mem_wr_en && $stable(st_q.acc)
    && mem_wdata == 8'($past(st_q.acc) + $past(mem_rdata)))
    else $error("plain add into memory wrong");
  a_and_only_zero: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op[2:1] == 2'b10 |=>
    st_q.result == ($past(st_q.acc) & $past(mem_rdata))
    && st_q.flags[ST_OV] == $past(st_q.flags[ST_OV])
    && st_q.flags[ST_C] == $past(st_q.flags[ST_C]))
    else $error("and result or flags wrong");
  a_andm_write: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_AND_INTO_MEM |=>
    mem_wr_en && mem_wdata == ($past(st_q.acc) & $past(mem_rdata)))
    else $error("and into memory not written");
  a_clr_byte: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_CLEAR_MEM_BYTE |=>
    mem_wr_en && mem_wdata == 8'h00 && $stable(st_q.flags))
    else $error("byte clear wrong");
  a_clr_bit: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op == OP_CLEAR_MEM_BIT |=>
    mem_wr_en && $stable(st_q.flags) && mem_wdata ==
    ($past(mem_rdata) & ~(8'h01 << $past(st_q.bit_sel))))
    else $error("bit clear wrong");
  a_zero_flag: assert property (@(posedge clk)
    disable iff (sys_rst)
    st_q.phase == st_exec && st_q.op[2:1] != 2'b11 |=>
    st_q.flags[ST_Z] == (st_q.result == 8'h00))
    else $error("zero flag disagrees with result");
  a_op_length: assert property (@(posedge clk) disable iff (sys_rst)
    mem_rd_en |=> st_q.phase == st_exec ##1 st_q.phase == st_idle)
    else $error("operation did not take three cycles");

  c_adc_carry: cover property (@(posedge clk) disable iff (sys_rst)
    st_q.phase == st_exec && use_cin && st_q.flags[ST_C]);
  c_mem_write: cover property (@(posedge clk) disable iff (sys_rst)
    mem_wr_en);
  c_bad_addr: cover property (@(posedge clk) disable iff (sys_rst)
    pready && pslverr);
  c_zero_set: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(st_q.flags[ST_Z]));
endmodule : extended_mem_alu_ops

// file: test/ext_mem_model.sv
// behavioural data memory on the far side of the extended ALU
`timescale 1ns/1ps
module ext_mem_model (
  input  wire logic                           clk,
  input  wire logic [ext_alu_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                           mem_rd_en,
  input  wire logic                           mem_wr_en,
  input  wire logic [7:0]                     mem_wdata,
  output logic      [7:0]                     mem_rdata
);
  import ext_alu_pkg::*;
  logic [7:0] mem_q [0:(1<<ADDR_W)-1];
  initial mem_rdata = 8'h5a;
  // outside the read cycle the bus flips, so stale data never looks valid
  always @(posedge clk) begin
    mem_rdata <= mem_rd_en ? mem_q[mem_addr] : ~mem_rdata;
    if (mem_wr_en) mem_q[mem_addr] <= mem_wdata;
  end
endmodule : ext_mem_model

// file: test/tb_extended_mem_alu_ops.sv
// self-checking bench for the extended memory ALU over APB
`timescale 1ns/1ps
module tb_extended_mem_alu_ops;
  import ext_alu_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0;
  logic [31:0]       prdata;
  logic              pready, pslverr, mem_rd_en, mem_wr_en, last_err;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0]        mem_wdata, mem_rdata;
  int                err_count = 0;
  int                checks_done = 0;

  always #20 clk = ~clk;

  extended_mem_alu_ops dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  ext_mem_model mem (.clk(clk), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
    .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask : chk

  // called right after a rising edge; one idle cycle follows each transfer
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      $display("FAIL pready expected 1 seen %b", pready);
      err_count++;
    end
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask : rd

  // returns {acc, mem, flags} after one operation
  function automatic logic [20:0] expect_of(input logic [2:0] op, b,
      input logic [7:0] a, m, input logic [4:0] f);
    logic [8:0] s;
    logic [4:0] lo, nf;
    logic [7:0] r, na, nm;
    logic       cin, ov;
    cin = (op == OP_ADD_MEM_TO_ACC_WITH_CARRY ||
           op == OP_ADD_WITH_CARRY_INTO_MEM) ? f[ST_C] : 1'b0;
    s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    lo = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    nf = f;
    if (op < 3'h4) begin
      r = s[7:0];
      ov = (a[7] == m[7]) && (r[7] != a[7]);
      nf = {ov ^ r[7], ov, r == 8'h00, lo[4], s[8]};
    end else if (op < 3'h6) begin
      r = a & m;
      nf[ST_Z] = (r == 8'h00);
    end else if (op == OP_CLEAR_MEM_BYTE) r = 8'h00;
    else r = m & ~(8'h01 << b);
    na = (op == 3'h0 || op == 3'h2 || op == 3'h4) ? r : a;
    nm = (op == 3'h0 || op == 3'h2 || op == 3'h4) ? m : r;
    return {na, nm, nf};
  endfunction : expect_of

  task automatic run_op(input logic [2:0] op, b, input logic [11:0] ad,
      input logic [7:0] a, m, input logic [4:0] f);
    logic [20:0] e;
    logic [31:0] q;
    logic [7:0]  r;
    int          n;
    e = expect_of(op, b, a, m, f);
    mem.mem_q[ad] = m;
    wr(OFS_ADDR, {20'h0, ad});
    wr(OFS_ACC, {24'h0, a});
    wr(OFS_STATUS, {27'h0, f});
    wr(OFS_CMD, {23'h0, 1'b1, 1'b0, b, 1'b0, op});
    n = 0;
    q = 32'h100;
    while (q[ST_BUSY] !== 1'b0 && n < 20) begin rd(OFS_STATUS, q); n++; end
    chk("busy", 8'h00, {7'h00, q[ST_BUSY]});
    chk("flags", {3'h0, e[4:0]}, q[7:0]);
    rd(OFS_ACC, q);
    chk("acc", e[20:13], q[7:0]);
    chk("mem", e[12:5], mem.mem_q[ad]);
    rd(OFS_CMD, q);
    chk("cmd op", {5'h00, op}, q[7:0]);
    // the last result is whatever landed at the destination
    r = (op == 3'h0 || op == 3'h2 || op == 3'h4) ? e[20:13] : e[12:5];
    rd(OFS_RESULT, q);
    chk("result", r, q[7:0]);
  endtask : run_op

  task automatic t_reset_vals;
    logic [31:0] q;
    rd(OFS_ACC, q);
    chk("acc reset", ACC_RST, q[7:0]);
    rd(OFS_STATUS, q);
    chk("status reset", 8'h00, q[7:0]);
    $display("test reset values done");
  endtask : t_reset_vals

  task automatic t_add_ops;
    run_op(3'h0, 3'h0, 12'hf3c, 8'h7f, 8'h01, 5'h01);
    run_op(3'h1, 3'h0, 12'h0a7, 8'h7f, 8'h01, 5'h01);
    run_op(3'h2, 3'h0, 12'h801, 8'h80, 8'h80, 5'h01);
    run_op(3'h3, 3'h0, 12'h3ff, 8'h0f, 8'h01, 5'h1f);
    $display("test add forms done");
  endtask : t_add_ops

  task automatic t_and_ops;
    run_op(3'h4, 3'h0, 12'h123, 8'hf0, 8'h0f, 5'h1b);
    run_op(3'h5, 3'h0, 12'hc00, 8'hff, 8'ha5, 5'h1f);
    $display("test and forms done");
  endtask : t_and_ops

  task automatic t_clear_ops;
    run_op(3'h6, 3'h0, 12'h555, 8'h3c, 8'hff, 5'h15);
    for (int i = 0; i < 8; i++)
      run_op(3'h7, i[2:0], 12'hfff, 8'h00, 8'hff, 5'h0a);
    $display("test clear forms done");
  endtask : t_clear_ops

  task automatic t_unmapped;
    logic [31:0] q;
    rd(8'h40, q);
    chk("slverr", 8'h01, {7'h0, last_err});
    chk("unmapped data", 8'h00, q[7:0]);
    $display("test unmapped address done");
  endtask : t_unmapped

  initial begin
    #200000;
    err_count++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_vals();
    t_add_ops();
    t_and_ops();
    t_clear_ops();
    t_unmapped();
    conclude();
  end
endmodule : tb_extended_mem_alu_ops
